// >>> rtl/epc_top.sv
`timescale 1ns/1ps
module epc_top
  import epc_pkg::*;
#(
  parameter int LONG_CYCLES  = EPC_LONG_CYCLES,   // 1 s interval, shorten in sim
  parameter int SHORT_CYCLES = EPC_SHORT_CYCLES   // 62.5 ms interval
) (
  input  wire logic        i_mclk,                  // 40 mhz clock
  input  wire logic        i_reset,                 // async reset, active high
  input  wire epc_strobe_t i_strobe,                // framer error strobes
  input  wire epc_sync_t   i_sync,                  // framer sync status
  input  wire logic        i_receive_sync_lost,     // loss-of-sync indication
  input  wire logic        i_count_interval_select, // 1 = 62.5 ms
  input  wire logic        i_violation_type_select, // 1 = code violations
  input  wire logic        i_receive_hdb3_enable,   // hdb3 decode on
  input  wire logic [7:0]  i_addr,                  // register address
  output logic [7:0]       o_rdata,                 // register read data
  output logic             o_interval_timer_flag    // pulse at boundary
);

  logic                     boundary;       // interval end pulse
  logic                     viol_inc;       // violation event this cycle
  logic                     frame_ok;       // fas and crc4 sync held
  logic [EPC_VIOL_W-1:0]    viol_count;     // latched counts of the last interval
  logic [EPC_CRC_W-1:0]     crc_count;
  logic [EPC_FAR_END_W-1:0] far_end_count;
  logic [EPC_FAS_W-1:0]     fas_count;
  logic [7:0]               next_rdata;

  // shared byte: six fas bits sit above a counter's two msbs
  function automatic logic [EPC_BYTE_W-1:0] pack_shared(
    input logic [EPC_FAS_PART_W-1:0] fas_part,   // fas bits for this byte
    input logic [EPC_MSB_W-1:0]      msbs        // crc or e-bit msbs
  );
    pack_shared = {fas_part, msbs};
  endfunction

  // interval source
  epc_interval_timer #(
    .LONG_CYCLES  (LONG_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  ) u_timer (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_short_sel (i_count_interval_select),  // [R1]
    .o_boundary  (boundary)
  );

  // event qualification; violation count ignores sync state
  always_comb begin
    if (i_violation_type_select) begin
      viol_inc = i_strobe.cv;                                        // [R6] [R8]
    end else begin
      viol_inc = i_strobe.bpv && !(i_receive_hdb3_enable && i_strobe.hdb3_code); // [R4] [R5]
    end
    // cas loss alone leaves crc and e-bit counting
    frame_ok = !i_sync.fas_lost && !i_sync.crc_lost;                 // [R11]
  end

  // 16-bit saturating violation counter
  epc_counter #(.W(EPC_VIOL_W)) u_viol (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_inc      (viol_inc),     // [R3] [R9]
    .i_boundary (boundary),
    .o_latched  (viol_count)
  );

  // crc4 codeword errors
  epc_counter #(.W(EPC_CRC_W)) u_crc (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_inc      (i_strobe.crc_err && frame_ok),    // [R10] [R11]
    .i_boundary (boundary),
    .o_latched  (crc_count)
  );

  // far-end block errors from zero e bits
  epc_counter #(.W(EPC_FAR_END_W)) u_far_end (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_inc      (i_strobe.ebit_zero && frame_ok),  // [R12] [R11]
    .i_boundary (boundary),
    .o_latched  (far_end_count)
  );

  // frame alignment word errors, held while sync lost
  epc_counter #(.W(EPC_FAS_W)) u_fas (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_inc      (i_strobe.fas_err && !i_receive_sync_lost),  // [R13]
    .i_boundary (boundary),
    .o_latched  (fas_count)
  );

  // read mux; shared bytes pack fas bits above the 2-bit msbs
  always_comb begin
    case (i_addr)
      EPC_ADDR_VIOL_HIGH: begin
        next_rdata = viol_count[EPC_VIOL_W-1 -: EPC_BYTE_W];                 // [R3]
      end
      EPC_ADDR_VIOL_LOW: begin
        next_rdata = viol_count[EPC_BYTE_W-1:0];                             // [R3]
      end
      EPC_ADDR_CRC_HIGH: begin
        // fas upper part above the crc msbs
        next_rdata = pack_shared(fas_count[EPC_FAS_W-1 -: EPC_FAS_PART_W],   // [R14]
                                 crc_count[EPC_CRC_W-1 -: EPC_MSB_W]);       // [R10]
      end
      EPC_ADDR_CRC_LOW: begin
        next_rdata = crc_count[EPC_BYTE_W-1:0];                              // [R10]
      end
      EPC_ADDR_FAR_END_HIGH: begin
        // fas lower part above the e-bit msbs
        next_rdata = pack_shared(fas_count[EPC_FAS_PART_W-1:0],             // [R14]
                                 far_end_count[EPC_FAR_END_W-1 -: EPC_MSB_W]); // [R12]
      end
      EPC_ADDR_FAR_END_LOW: begin
        next_rdata = far_end_count[EPC_BYTE_W-1:0];                          // [R12]
      end
      default: begin
        next_rdata = 8'h00;                   // unmapped reads as zero
      end
    endcase
  end

  // registered read data, one cycle after the address
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata               <= 8'h00;
      o_interval_timer_flag <= 1'b0;
    end else begin
      o_rdata               <= next_rdata;
      o_interval_timer_flag <= boundary;   // latched regs valid from this edge
    end
  end

endmodule

// >>> pkg/epc_pkg.sv
// Overview of operation
// R1: refresh all counts together each interval
// R2: host reads latched counts within one interval
// R3: 16-bit violation count, high then low byte
// R4: select 0 counts bipolar violations
// R5: hdb3 substitution violations not counted as bipolar
// R6: select 1 counts code violations
// R7: host picks bipolar for ami, code for hdb3
// R8: violation counting ignores loss of sync
// R9: violation count saturates at 65535
// R10: 10-bit crc4 error count, msbs in bits 1..0
// R11: crc and e-bit counts stop on sync loss
// R12: 10-bit e-bit count, one per zero e bit
// R13: 12-bit fas error count, held during sync loss
// R14: fas bits packed above crc and e-bit msbs
// R15: boundary copies counts and restarts from zero
package epc_pkg;

  // register offsets on the byte port
  localparam logic [7:0] EPC_ADDR_VIOL_HIGH  = 8'h00;
  localparam logic [7:0] EPC_ADDR_VIOL_LOW   = 8'h01;
  localparam logic [7:0] EPC_ADDR_CRC_HIGH   = 8'h02;
  localparam logic [7:0] EPC_ADDR_CRC_LOW    = 8'h03;
  localparam logic [7:0] EPC_ADDR_FAR_END_HIGH = 8'h04;
  localparam logic [7:0] EPC_ADDR_FAR_END_LOW  = 8'h05;

  // counter widths
  localparam int EPC_VIOL_W    = 16;
  localparam int EPC_CRC_W     = 10;
  localparam int EPC_FAR_END_W = 10;
  localparam int EPC_FAS_W     = 12;

  // byte port layout; shared bytes carry six fas bits over two msbs
  localparam int EPC_BYTE_W     = 8;
  localparam int EPC_MSB_W      = 2;
  localparam int EPC_FAS_PART_W = 6;

  // saturation ceiling of the violation counter
  localparam logic [15:0] EPC_VIOL_MAX = 16'hffff;

  // interval timing, figures in microseconds
  localparam int    EPC_CLK_HZ       = 40_000_000;
  localparam real   EPC_LONG_US      = 1_000_000.0;
  localparam real   EPC_SHORT_US     = 62_500.0;
  localparam int    EPC_LONG_CYCLES  = int'(EPC_LONG_US * EPC_CLK_HZ / 1.0e6);
  localparam int    EPC_SHORT_CYCLES = int'(EPC_SHORT_US * EPC_CLK_HZ / 1.0e6);
  localparam int    EPC_TMR_W        = 26;

  // error strobes from the receive framer
  typedef struct packed {
    logic bpv;         // same-polarity successive marks
    logic hdb3_code;   // this violation lies in a valid hdb3 substitution
    logic cv;          // violation of same polarity as previous violation
    logic crc_err;     // crc4 sub-multiframe codeword error
    logic ebit_zero;   // received e bit equal to zero
    logic fas_err;     // errored frame alignment word
  } epc_strobe_t;

  // sync status from the framer
  typedef struct packed {
    logic fas_lost;    // frame alignment lost
    logic crc_lost;    // crc4 multiframe sync lost
    logic cas_lost;    // cas multiframe sync lost (does not stop counts)
  } epc_sync_t;

endpackage

// >>> rtl/epc_interval_timer.sv
`timescale 1ns/1ps
module epc_interval_timer
  import epc_pkg::*;
#(
  parameter int LONG_CYCLES  = EPC_LONG_CYCLES,
  parameter int SHORT_CYCLES = EPC_SHORT_CYCLES
) (
  input  wire logic i_mclk,           // 40 mhz clock
  input  wire logic i_reset,          // async reset, active high
  input  wire logic i_short_sel,      // 1 = 62.5 ms interval
  output logic      o_boundary        // one-cycle pulse at interval end
);

  logic [EPC_TMR_W-1:0] count;        // cycles into current interval
  logic [EPC_TMR_W-1:0] next_count;
  logic [EPC_TMR_W-1:0] last;         // terminal count for chosen interval

  // terminal count; a mode change mid-interval takes effect at once
  always_comb begin
    last = i_short_sel ? EPC_TMR_W'(SHORT_CYCLES - 1) : EPC_TMR_W'(LONG_CYCLES - 1);
    o_boundary = (count >= last);     // [R1]
    next_count = o_boundary ? '0 : count + EPC_TMR_W'(1);
  end

  // register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// >>> rtl/epc_counter.sv
`timescale 1ns/1ps
module epc_counter
  import epc_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         i_mclk,     // clock
  input  wire logic         i_reset,    // async reset, active high
  input  wire logic         i_inc,      // count one event
  input  wire logic         i_boundary, // interval end
  output logic [W-1:0]      o_latched   // count of last interval
);

  logic [W-1:0] run;                  // running count
  logic [W-1:0] next_run;
  logic [W-1:0] next_latched;

  // one step up, held at all ones so the count never wraps
  function automatic logic [W-1:0] sat_inc(
    input logic [W-1:0] value,        // count before the event
    input logic         hit           // event seen this cycle
  );
    sat_inc = (hit && value != {W{1'b1}}) ? value + W'(1) : value;
  endfunction

  // boundary copies the running count out and restarts it
  always_comb begin
    next_latched = o_latched;
    next_run     = sat_inc(run, i_inc);      // [R9]
    if (i_boundary) begin
      // event in the boundary cycle goes to the closing interval
      next_latched = sat_inc(run, i_inc);    // [R15] [R1]
      next_run     = '0;                     // [R15]
    end
  end

  // register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      run       <= '0;
      o_latched <= '0;
    end else begin
      run       <= next_run;
      o_latched <= next_latched;
    end
  end

endmodule

// >>> tb/epc_top_monitor.sv
`timescale 1ns/1ps
module epc_top_monitor
  import epc_pkg::*;
#(
  parameter int LONG_CYCLES  = 200, // long interval
  parameter int SHORT_CYCLES = 50   // short interval
) (
  input wire logic        i_mclk,                  // clock
  input wire logic        i_reset,                 // async reset
  input wire epc_strobe_t i_strobe,                // strobes
  input wire logic        i_count_interval_select, // 1 = short
  input wire logic [7:0]  i_addr,                  // address
  input wire logic [7:0]  o_rdata,                 // read data
  input wire logic        o_interval_timer_flag    // boundary
);
  wire  flag = o_interval_timer_flag; // short alias
  int   gap;  // cycles since last flag
  logic seen; // a flag since reset, so gap is meaningful
  logic busy; // any strobe in the closing interval
  // helper state; busy is a superset, so quiet means truly quiet
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gap  <= 0;
      seen <= 1'b0;
      busy <= 1'b0;
    end else begin
      gap  <= flag ? 0 : gap + 1;
      seen <= seen | flag;
      busy <= (busy & ~flag) | (|i_strobe);
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_flag_single: assert property (flag |=> !flag)
    else $error("flag longer than one cycle");
  a_flag_period: assert property (
    flag && seen |-> gap == (i_count_interval_select ? SHORT_CYCLES : LONG_CYCLES) - 1)
    else $error("interval length wrong");
  a_flag_reset: assert property ($fell(i_reset) |-> !flag)
    else $error("flag right after reset");
  a_rdata_reset: assert property ($fell(i_reset) |-> o_rdata == 8'h00)
    else $error("read data not clear after reset");
  a_unmapped_zero: assert property (i_addr > 8'h05 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($stable(i_addr) && !flag |=> $stable(o_rdata))
    else $error("read data moved mid interval");
  a_quiet_zero: assert property (flag && !busy |=> o_rdata == 8'h00)
    else $error("quiet interval not zero");
  a_steady_read: assert property (flag ##1 $stable(i_addr)[*3] |=> $stable(o_rdata)[*2])
    else $error("latched count not steady");
endmodule
bind epc_top epc_top_monitor #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES))
  i_epc_top_monitor (.i_mclk(i_mclk), .i_reset(i_reset), .i_strobe(i_strobe),
  .i_count_interval_select(i_count_interval_select), .i_addr(i_addr),
  .o_rdata(o_rdata), .o_interval_timer_flag(o_interval_timer_flag));

// >>> tb/epc_framer_model.sv
`timescale 1ns/1ps
module epc_framer_model
  import epc_pkg::*;
(
  input  wire logic  i_mclk,   // line clock
  output epc_strobe_t o_strobe // error strobes
);
  initial o_strobe = '0; // idle framer flags nothing
  // n back-to-back one-cycle events, moved at the falling edge
  task automatic send(input epc_strobe_t s, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge i_mclk);
      o_strobe = s;
    end
    @(negedge i_mclk);
    o_strobe = '0;
  endtask
endmodule

// >>> tb/epc_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module epc_top_tb_top;
  import epc_pkg::*;
  logic        mclk       = 1'b0;  // line clock
  logic        reset      = 1'b1;  // async reset
  epc_strobe_t strobe;             // framer strobes
  epc_sync_t   sync       = '1;    // all sync lost at start
  logic        rslost     = 1'b1;  // loss-of-sync level
  logic        isel       = 1'b0;  // interval select
  logic        vsel       = 1'b0;  // violation type select
  logic        hdb3       = 1'b1;  // hdb3 decode on
  logic [7:0]  addr       = 8'h00; // read address
  logic [7:0]  rdata;              // read data
  logic        flag;               // boundary pulse
  int          err_count  = 0;     // mismatches
  int          num_checks = 0;     // comparisons
  int          tn         = 0;     // tests done
  always #12.5 mclk = ~mclk;
  epc_framer_model i_epc_framer_model (.i_mclk(mclk), .o_strobe(strobe));
  // long interval just above the violation ceiling, so saturation fits in one
  epc_top #(.LONG_CYCLES(66000), .SHORT_CYCLES(50)) i_epc_top (
    .i_mclk(mclk), .i_reset(reset), .i_strobe(strobe), .i_sync(sync),
    .i_receive_sync_lost(rslost), .i_count_interval_select(isel),
    .i_violation_type_select(vsel), .i_receive_hdb3_enable(hdb3), .i_addr(addr),
    .o_rdata(rdata), .o_interval_timer_flag(flag));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // seen at the falling edge, so the flag is settled
  task automatic wait_flag();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (flag !== 1'b1 && k < 70000);
    if (flag !== 1'b1) err_count++;
  endtask
  // reads every byte plus one unmapped place
  task automatic check_regs(input logic [15:0] v, input logic [9:0] c, e,
                            input logic [11:0] f);
    logic [7:0] x [7];
    x = '{v[15:8], v[7:0], {f[11:6], c[9:8]}, c[7:0], {f[5:0], e[9:8]}, e[7:0], 8'h00};
    for (int a = 0; a < 7; a++) begin
      addr = 8'(a);
      @(negedge mclk);
      `CHK(rdata, x[a])
    end
  endtask
  // events in one interval, read at once after the boundary
  task automatic run(input epc_strobe_t s, input int n, input logic [15:0] v,
                     input logic [9:0] c, e, input logic [11:0] f);
    i_epc_framer_model.send(s, n);
    addr = EPC_ADDR_VIOL_LOW; // park on a live byte so the quiet-interval check can trip
    wait_flag();
    check_regs(v, c, e, f);
    tn++;
    $display("test %0d done", tn);
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    run(6'b100111, 65537, 16'hffff, 10'h0, 10'h0, 12'h0);
    reset = 1'b1;
    isel = 1'b1;
    sync = '0;
    rslost = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    wait_flag();
    run(6'b110000, 5, 16'h0, 10'h0, 10'h0, 12'h0);
    hdb3 = 1'b0;
    run(6'b110000, 4, 16'h4, 10'h0, 10'h0, 12'h0);
    vsel = 1'b1;
    sync = 3'b001;
    run(6'b001111, 6, 16'h6, 10'h6, 10'h6, 12'h6);
    sync = 3'b100;
    run(6'b101111, 3, 16'h3, 10'h0, 10'h0, 12'h3);
    sync = 3'b010;
    rslost = 1'b1;
    run(6'b001111, 2, 16'h2, 10'h0, 10'h0, 12'h0);
    run(6'b000000, 0, 16'h0, 10'h0, 10'h0, 12'h0);
    results();
  end
  // whole run is about 66400 cycles; the guard leaves margin yet stays short
  initial begin
    #(25.0 * 80000);
    err_count++;
    results();
  end
endmodule
